// ==== design/mtg_timer_group.sv ====
// What this block does
// R1: five 16-bit channels, independent except when one counts another's wraps
// R2: timer mode counts the internal prescaled tick
// R3: event mode counts pin pulses or another channel's overflow/underflow
// R4: one-shot gives one pulse per start, ending when count reaches zero
// R5: pwm mode emits a continuous pulse train of programmed width and fixed PWM_PERIOD period
// R6: programmable output has separate high and low times, channels 1, 2, 4
// R7: quadrature counting exists only on channels 2, 3 and 4
// R8: timer mode uses the input pin as a counting gate
// R9: single-phase event mode counts pulses on the input pin
// R10: one-shot, pwm and programmable modes start from the input pin trigger
// R11: output pin carries the generated waveform in every mode except two-phase
// R12: two-phase mode turns the output pin into the second phase input
// R13: two-phase mode takes the first phase from the input pin
// R14: active index input clears the counter in two-phase mode
// R15: each channel flags its own overflow or underflow
// R16: each channel's wrap event feeds other channels' event counting
// R17: mode field 11b selects pulse family, variant bit 0 selects 16-bit
// R18: select bit picks pwm when clear, programmable output when set
`timescale 1ns/100ps
module mtg_timer_group (
  // clock and reset
  input  wire logic                                   sys_clk,
  input  wire logic                                   reset_n,
  // channel settings
  input  wire mtg_pkg::mtg_chan_mode_reg_t [4:0]      chanModeReg,
  // pins
  input  wire logic [4:0]                             chanInPin,
  input  wire logic [4:0]                             chanOutPinIn,
  input  wire logic                                   indexPhaseIn,
  output logic [4:0]                                  chanOutPinOut,
  output logic [4:0]                                  chanOutPinOe,
  // status
  output logic [4:0]                                  chanIrqReq,
  output logic [4:0][15:0]                            chanCount
);

  logic [mtg_pkg::PRESCALE_W-1:0] prescCnt_ff;
  logic [mtg_pkg::PRESCALE_W-1:0] nxt_prescCnt;
  logic                           prescWrap;
  logic                           tick_ff;
  logic                           nxt_tick;
  logic [4:0]                     wrapEvt;

  // divider wrap and next values
  assign prescWrap    = prescCnt_ff == mtg_pkg::PRESCALE_MAX;
  assign nxt_prescCnt = prescWrap ? '0 : prescCnt_ff + 1'b1;
  assign nxt_tick     = prescWrap; // R2

  // free-running divider
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescCnt_ff <= '0;
    end else begin
      prescCnt_ff <= nxt_prescCnt;
    end
  end

  // one-cycle internal tick, shared by all channels
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  // flagged wraps double as other channels' count source
  assign wrapEvt = chanIrqReq; // R16

  genvar i;
  generate
    for (i = 0; i < mtg_pkg::NUM_CHAN; i++) begin : gChan // R1
      mtg_pkg::mtg_chan_mode_reg_t cfg;
      mtg_pkg::mtg_phase_t         phase_ff;
      mtg_pkg::mtg_phase_t         nxt_phase;
      logic [15:0]                 cnt_ff;
      logic [15:0]                 nxt_cnt;
      logic                        wave_ff;
      logic                        nxt_wave;
      logic                        wrap_ff;
      logic                        nxt_wrap;
      logic                        oe_ff;
      logic                        pinOut_ff;
      logic                        inPrev_ff;
      logic                        phBPrev_ff;
      wire                         isTimer;
      wire                         isEvent;
      wire                         isOneShot;
      wire                         isPulse;
      wire                         quadOn;
      wire                         progOn;
      wire                         inRise;
      wire                         gateOpen;
      wire                         timerStep;
      wire                         quadStep;
      wire                         quadUp;
      wire                         evStep;
      wire                         evUp;
      wire                         trig;
      wire                         atZero;
      wire                         atFull;
      wire                         lastTick;
      wire [15:0]                  lowLen;
      wire                         nxt_oe;
      wire                         nxt_pinOut;
      wire                         aEdge;
      wire                         bEdge;
      wire                         srcWrap;
      wire                         phaseEnd;
      wire                         highOn;
      wire [15:0]                  downCnt;
      wire [15:0]                  upCnt;

      assign cfg = chanModeReg[i];

      // mode decode
      assign isTimer   = cfg.opModeField == mtg_pkg::MODE_TIMER;
      assign isEvent   = cfg.opModeField == mtg_pkg::MODE_EVENT;
      assign isOneShot = cfg.opModeField == mtg_pkg::MODE_ONESHOT;
      assign isPulse   = (cfg.opModeField == mtg_pkg::MODE_PULSE)
                         & ~cfg.pulseWidthVariantBit; // R17
      assign quadOn    = isEvent & cfg.twoPhase & mtg_pkg::QUAD_CAPABLE[i]; // R7
      assign progOn    = isPulse & cfg.progOutSelectBit & mtg_pkg::PROG_CAPABLE[i]; // R6 R18

      // pin edges and gate
      assign inRise    = chanInPin[i] & ~inPrev_ff;
      assign gateOpen  = ~cfg.gateEnable | (chanInPin[i] == cfg.gateLevel); // R8
      assign timerStep = tick_ff & gateOpen; // R2

      // quadrature decode, phase a on input pin, phase b on output pin
      assign aEdge     = chanInPin[i] ^ inPrev_ff; // R13
      assign bEdge     = chanOutPinIn[i] ^ phBPrev_ff; // R12
      assign quadStep  = aEdge ^ bEdge; // both moving at once is dropped
      assign quadUp    = inPrev_ff ^ chanOutPinIn[i]; // R12

      // chained source; an index past the last channel never steps
      assign srcWrap = (cfg.eventSrcIdx < 3'(mtg_pkg::NUM_CHAN)) ? wrapEvt[cfg.eventSrcIdx]
                                                                 : 1'b0; // R16

      // event source selection
      assign evStep = quadOn ? quadStep
                    : (cfg.eventSrcOther ? srcWrap : inRise); // R3 R9
      assign evUp   = quadOn ? quadUp : cfg.countUp;

      // start trigger for pulse modes
      assign trig     = cfg.countStart & (cfg.extTrigger ? inRise : cfg.oneShotStart); // R10
      assign atZero   = cnt_ff == mtg_pkg::CNT_ZERO;
      assign atFull   = cnt_ff == mtg_pkg::CNT_FULL;
      assign lastTick = tick_ff & (cnt_ff <= mtg_pkg::CNT_ONE);
      assign lowLen   = progOn ? cfg.lowVal : (mtg_pkg::PWM_PERIOD - cfg.reloadVal); // R5 R6

      // shared end-of-phase and reload arithmetic
      assign phaseEnd = lastTick | atZero;
      assign highOn   = cfg.reloadVal != mtg_pkg::CNT_ZERO;
      assign downCnt  = atZero ? cfg.reloadVal : cnt_ff - 1'b1;
      assign upCnt    = atFull ? cfg.reloadVal : cnt_ff + 1'b1;

      // next state of counter, phase and waveform
      always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_phase = phase_ff;
        nxt_wave  = wave_ff;
        nxt_wrap  = 1'b0;
        if (!cfg.countStart) begin
          nxt_phase = mtg_pkg::PH_IDLE;
          if (isOneShot || isPulse) begin
            nxt_wave = 1'b0;
          end
        end else if (isTimer) begin
          if (timerStep) begin
            nxt_cnt = downCnt;
            nxt_wrap = atZero; // R15
            nxt_wave = atZero ? ~wave_ff : wave_ff; // R11
          end
        end else if (isEvent) begin
          if (quadOn && cfg.indexEnable && indexPhaseIn) begin
            nxt_cnt = mtg_pkg::CNT_ZERO; // R14
          end else if (evStep) begin
            if (evUp) begin
              nxt_cnt  = upCnt;
              nxt_wrap = atFull; // R15
            end else begin
              nxt_cnt  = downCnt;
              nxt_wrap = atZero; // R15
            end
            nxt_wave = nxt_wrap ? ~wave_ff : wave_ff; // R11
          end
        end else if (isOneShot) begin
          case (phase_ff)
            mtg_pkg::PH_IDLE: begin
              if (trig) begin
                nxt_cnt   = cfg.reloadVal;
                nxt_phase = mtg_pkg::PH_HIGH;
                nxt_wave  = 1'b1;
              end
            end
            mtg_pkg::PH_HIGH: begin
              if (phaseEnd) begin
                nxt_cnt   = mtg_pkg::CNT_ZERO;
                nxt_phase = mtg_pkg::PH_IDLE;
                nxt_wave  = 1'b0; // R4
                nxt_wrap  = 1'b1;
              end else if (tick_ff) begin
                nxt_cnt = cnt_ff - 1'b1;
              end
            end
            default: begin
              nxt_phase = mtg_pkg::PH_IDLE;
              nxt_wave  = 1'b0;
            end
          endcase
        end else if (isPulse) begin
          case (phase_ff)
            mtg_pkg::PH_IDLE: begin
              if (trig) begin
                nxt_cnt   = cfg.reloadVal;
                nxt_phase = mtg_pkg::PH_HIGH;
                nxt_wave  = highOn;
              end
            end
            mtg_pkg::PH_HIGH: begin
              if (phaseEnd) begin
                nxt_cnt   = lowLen;
                nxt_phase = mtg_pkg::PH_LOW;
                nxt_wave  = 1'b0;
              end else if (tick_ff) begin
                nxt_cnt = cnt_ff - 1'b1;
              end
            end
            mtg_pkg::PH_LOW: begin
              if (phaseEnd) begin
                nxt_cnt   = cfg.reloadVal;
                nxt_phase = mtg_pkg::PH_HIGH; // R5
                nxt_wave  = highOn;
                nxt_wrap  = 1'b1;
              end else if (tick_ff) begin
                nxt_cnt = cnt_ff - 1'b1;
              end
            end
            default: begin
              nxt_phase = mtg_pkg::PH_IDLE;
            end
          endcase
        end else begin
          nxt_phase = mtg_pkg::PH_IDLE; // 8-bit variant not built
          nxt_wave  = 1'b0;
        end
      end

      // pin drive: released in two-phase mode, low-only on open-drain channel
      assign nxt_oe     = quadOn ? 1'b0
                        : ((i == mtg_pkg::OPEN_DRAIN_CHAN) ? ~nxt_wave : 1'b1); // R12
      assign nxt_pinOut = (i == mtg_pkg::OPEN_DRAIN_CHAN) ? 1'b0 : nxt_wave; // R11

      // counter, phase and waveform
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_ff   <= mtg_pkg::CNT_ZERO;
          phase_ff <= mtg_pkg::PH_IDLE;
          wave_ff  <= 1'b0;
        end else begin
          cnt_ff   <= nxt_cnt;
          phase_ff <= nxt_phase;
          wave_ff  <= nxt_wave;
        end
      end

      // one-cycle wrap flag
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          wrap_ff <= 1'b0;
        end else begin
          wrap_ff <= nxt_wrap; // R15
        end
      end

      // registered pin drive
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          oe_ff     <= 1'b0;
          pinOut_ff <= 1'b0;
        end else begin
          oe_ff     <= nxt_oe;
          pinOut_ff <= nxt_pinOut;
        end
      end

      // previous pin levels for edge and phase decode
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          inPrev_ff  <= 1'b0;
          phBPrev_ff <= 1'b0;
        end else begin
          inPrev_ff  <= chanInPin[i];
          phBPrev_ff <= chanOutPinIn[i];
        end
      end

      // outputs straight from flops
      assign chanCount[i]     = cnt_ff;
      assign chanIrqReq[i]    = wrap_ff; // R15
      assign chanOutPinOut[i] = pinOut_ff;
      assign chanOutPinOe[i]  = oe_ff;
    end
  endgenerate

endmodule // mtg_timer_group

// ==== design/mtg_pkg.sv ====
package mtg_pkg;

  // channel count and counter width
  localparam int          NUM_CHAN = 5;
  localparam int          CNT_W    = 16;

  // operating mode field encodings
  localparam logic [1:0]  MODE_TIMER   = 2'h0;
  localparam logic [1:0]  MODE_EVENT   = 2'h1;
  localparam logic [1:0]  MODE_ONESHOT = 2'h2;
  localparam logic [1:0]  MODE_PULSE   = 2'h3;

  // per-channel capability masks, bit i is channel i
  localparam logic [4:0]  QUAD_CAPABLE = 5'h1c;
  localparam logic [4:0]  PROG_CAPABLE = 5'h16;

  // open-drain channel index
  localparam int          OPEN_DRAIN_CHAN = 0;

  // internal count source divider
  localparam int          PRESCALE_W   = 8;
  localparam logic [7:0]  PRESCALE_MAX = 8'h07;

  // counter constants
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [15:0] CNT_FULL  = 16'hffff;
  localparam logic [15:0] PWM_PERIOD = 16'hffff;

  // waveform phase, gray along idle -> high -> low
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HIGH = 2'b01,
    PH_LOW  = 2'b11
  } mtg_phase_t;

  // channel mode register and its companion settings
  typedef struct packed {
    logic [1:0]  opModeField;          // timer, event, one-shot, pulse
    logic        pulseWidthVariantBit; // 0 selects the 16-bit pulse variant
    logic        progOutSelectBit;     // 0 pwm, 1 programmable output
    logic        countStart;           // channel runs while high
    logic        gateEnable;           // timer mode: pin gates counting
    logic        gateLevel;            // pin level that lets counting run
    logic        extTrigger;           // start from pin rising edge
    logic        oneShotStart;         // software start pulse
    logic        eventSrcOther;        // count other channel's wrap events
    logic [2:0]  eventSrcIdx;          // which channel to follow
    logic        countUp;              // single-phase direction
    logic        twoPhase;             // quadrature decoding
    logic        indexEnable;          // index pin clears counter
    logic [15:0] reloadVal;            // reload / high duration
    logic [15:0] lowVal;               // low duration, programmable output
  } mtg_chan_mode_reg_t;

endpackage

// ==== sim/mtg_timer_group_checker.sv ====
`timescale 1ns/100ps
module mtg_timer_group_checker (
  // clock and reset
  input wire logic                              sys_clk,
  input wire logic                              reset_n,
  // watched ports
  input wire mtg_pkg::mtg_chan_mode_reg_t [4:0] chanModeReg,
  input wire logic [4:0]                        chanInPin,
  input wire logic [4:0]                        chanOutPinIn,
  input wire logic                              indexPhaseIn,
  input wire logic [4:0]                        chanOutPinOut,
  input wire logic [4:0]                        chanOutPinOe,
  input wire logic [4:0]                        chanIrqReq,
  input wire logic [4:0][15:0]                  chanCount
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ch1 timer with gate shut
  sequence gateShut;
    chanModeReg[1].opModeField == mtg_pkg::MODE_TIMER && chanModeReg[1].countStart &&
      chanModeReg[1].gateEnable && chanInPin[1] != chanModeReg[1].gateLevel;
  endsequence

  // irq pulses, pin roles, stop, gate, tick spacing, one-shot end
  a_irq_single_cycle: assert property ((chanIrqReq & $past(chanIrqReq)) == 5'h00)
    else $error("irq held two cycles");
  a_ch0_open_drain: assert property (chanOutPinOut[0] == 1'b0)
    else $error("ch0 drove high");
  a_two_phase_input: assert property (
    chanModeReg[2].opModeField == mtg_pkg::MODE_EVENT && chanModeReg[2].twoPhase
      |=> !chanOutPinOe[2])
    else $error("ch2 drives pin in two-phase");
  a_index_clears: assert property (
    chanModeReg[2].opModeField == mtg_pkg::MODE_EVENT && chanModeReg[2].twoPhase &&
      chanModeReg[2].indexEnable && chanModeReg[2].countStart && indexPhaseIn
      |=> chanCount[2] == mtg_pkg::CNT_ZERO)
    else $error("index did not clear");
  a_stop_freezes: assert property ((!chanModeReg[1].countStart)[*2] |-> $stable(chanCount[1]))
    else $error("stopped ch1 moved");
  a_gate_blocks: assert property (gateShut[*2] |-> $stable(chanCount[1]))
    else $error("gate did not block");
  a_tick_spacing: assert property (
    chanModeReg[1].opModeField == mtg_pkg::MODE_TIMER && $changed(chanCount[1]) &&
      chanModeReg[1].countStart |=> $stable(chanCount[1])[*7])
    else $error("timer stepped faster than tick");
  a_oneshot_end: assert property (
    chanModeReg[3].opModeField == mtg_pkg::MODE_ONESHOT && chanModeReg[3].countStart &&
      $fell(chanOutPinOut[3]) |-> chanIrqReq[3] && chanCount[3] == mtg_pkg::CNT_ZERO)
    else $error("one-shot end wrong");

  // main scenarios reached
  c_timer_wrap: cover property (chanIrqReq[1]);
  c_index: cover property (indexPhaseIn && chanModeReg[2].indexEnable);
  c_oneshot: cover property ($fell(chanOutPinOut[3]));
  c_prog_low: cover property ($fell(chanOutPinOut[4]));
endmodule // mtg_timer_group_checker

// ==== sim/mtg_pin_model.sv ====
`timescale 1ns/100ps
module mtg_pin_model (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // encoder control
  input wire logic       step,
  output logic           phA,
  // output pins
  input wire logic [4:0] pinOut,
  input wire logic [4:0] pinOe,
  output logic [4:0]     pinLevel
);
  logic [1:0] quad_ff;

  // quadrature encoder turning forward one step a request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) quad_ff <= 2'h0;
    else if (step) quad_ff <= quad_ff + 2'h1;
  end
  assign phA = quad_ff[1];

  // pin levels: ch0 pulled up, ch2 driven by encoder when released
  assign pinLevel[0] = pinOe[0] ? pinOut[0] : 1'b1;
  assign pinLevel[1] = pinOe[1] ? pinOut[1] : 1'b0;
  assign pinLevel[2] = pinOe[2] ? pinOut[2] : quad_ff[1] ^ quad_ff[0];
  assign pinLevel[4:3] = pinOe[4:3] & pinOut[4:3];
endmodule // mtg_pin_model

// ==== sim/mtg_timer_group_tb.sv ====
`timescale 1ns/100ps
module mtg_timer_group_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  mtg_pkg::mtg_chan_mode_reg_t [4:0] modeReg = '0;
  logic [4:0] tbIn = 5'h00;
  logic index = 1'b0, quadOn = 1'b0, step = 1'b0, phA;
  logic [4:0] outPin, outOe, irq, pinLvl, inPin;
  logic [4:0][15:0] count;
  int fails = 0, checks = 0, n;
  logic [15:0] held;

  assign inPin = {tbIn[4:3], quadOn ? phA : tbIn[2], tbIn[1:0]};

  // dut and far side
  mtg_timer_group mtg_timer_group_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .chanModeReg(modeReg), .chanInPin(inPin), .chanOutPinIn(pinLvl),
    .indexPhaseIn(index), .chanOutPinOut(outPin), .chanOutPinOe(outOe),
    .chanIrqReq(irq), .chanCount(count));
  mtg_pin_model mtg_pin_model_inst (.sys_clk(sys_clk), .reset_n(reset_n), .step(step),
    .phA(phA), .pinOut(outPin), .pinOe(outOe), .pinLevel(pinLvl));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic results();
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bounded waits for irq or an output level, counted in cycles
  task automatic waitIrq(input int ch, output int cnt);
    cnt = 0;
    while (irq[ch] !== 1'b1 && cnt < 400) begin
      @(negedge sys_clk);
      cnt++;
    end
    if (cnt >= 400) begin
      fails++;
      results();
    end
  endtask

  task automatic waitOut(input int ch, input logic lvl, output int cnt);
    cnt = 0;
    while (outPin[ch] !== lvl && cnt < 400) begin
      @(negedge sys_clk);
      cnt++;
    end
    if (cnt >= 400) begin
      fails++;
      results();
    end
  endtask

  task automatic pulseIn(input int ch);
    tbIn[ch] = 1'b1;
    repeat (2) @(negedge sys_clk);
    tbIn[ch] = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  // timer period and gate on ch1
  task automatic testTimer();
    modeReg[1].reloadVal = 16'h0003;
    modeReg[1].gateEnable = 1'b1;
    modeReg[1].gateLevel = 1'b1;
    tbIn[1] = 1'b1;
    modeReg[1].countStart = 1'b1;
    waitIrq(1, n);
    @(negedge sys_clk);
    waitIrq(1, n);
    chk("timer period", 16'h001f, 16'(n));
    tbIn[1] = 1'b0;
    repeat (3) @(negedge sys_clk);
    held = count[1];
    repeat (40) @(negedge sys_clk);
    chk("gated count", held, count[1]);
    modeReg[1].countStart = 1'b0;
  endtask

  // pin pulses on ch0, ch3 follows ch0 wraps
  task automatic testEvent();
    modeReg[0].opModeField = mtg_pkg::MODE_EVENT;
    modeReg[0].reloadVal = 16'h0005;
    modeReg[3].opModeField = mtg_pkg::MODE_EVENT;
    modeReg[3].eventSrcOther = 1'b1;
    modeReg[3].countUp = 1'b1;
    modeReg[0].countStart = 1'b1;
    modeReg[3].countStart = 1'b1;
    repeat (3) pulseIn(0);
    chk("event count", 16'h0003, count[0]);
    chk("chained count", 16'h0001, count[3]);
    modeReg[0].countStart = 1'b0;
    modeReg[3] = '0;
  endtask

  // quadrature on ch2 with index clear
  task automatic testQuad();
    modeReg[2].opModeField = mtg_pkg::MODE_EVENT;
    modeReg[2].twoPhase = 1'b1;
    modeReg[2].indexEnable = 1'b1;
    modeReg[2].countStart = 1'b1;
    quadOn = 1'b1;
    repeat (3) @(negedge sys_clk);
    repeat (4) begin
      step = 1'b1;
      @(negedge sys_clk);
      step = 1'b0;
      repeat (3) @(negedge sys_clk);
    end
    chk("quad count", 16'h0004, count[2]);
    index = 1'b1;
    repeat (2) @(negedge sys_clk);
    index = 1'b0;
    chk("index count", 16'h0000, count[2]);
    modeReg[2].countStart = 1'b0;
  endtask

  // one pulse per pin trigger on ch3
  task automatic testOneShot();
    modeReg[3].opModeField = mtg_pkg::MODE_ONESHOT;
    modeReg[3].reloadVal = 16'h0002;
    modeReg[3].extTrigger = 1'b1;
    modeReg[3].countStart = 1'b1;
    @(negedge sys_clk);
    tbIn[3] = 1'b1;
    waitOut(3, 1'b1, n);
    waitOut(3, 1'b0, n);
    repeat (60) @(negedge sys_clk);
    chk("one-shot after", 16'h0000, {15'h0000, outPin[3]});
    chk("one-shot count", 16'h0000, count[3]);
    tbIn[3] = 1'b0;
  endtask

  // pwm on ch3, where the programmable select must be ignored
  task automatic testPwm();
    modeReg[3] = '0;
    modeReg[3].opModeField = mtg_pkg::MODE_PULSE;
    modeReg[3].progOutSelectBit = 1'b1;
    modeReg[3].reloadVal = 16'h0002;
    modeReg[3].lowVal = 16'h0005;
    modeReg[3].countStart = 1'b1;
    modeReg[3].oneShotStart = 1'b1;
    @(negedge sys_clk);
    modeReg[3].oneShotStart = 1'b0;
    waitOut(3, 1'b1, n);
    waitOut(3, 1'b0, n);
    repeat (60) @(negedge sys_clk);
    chk("pwm long low", 16'h0000, {15'h0000, outPin[3]});
    modeReg[3].countStart = 1'b0;
  endtask

  // programmable high and low times on ch4
  task automatic testProg();
    modeReg[4].opModeField = mtg_pkg::MODE_PULSE;
    modeReg[4].progOutSelectBit = 1'b1;
    modeReg[4].reloadVal = 16'h0002;
    modeReg[4].lowVal = 16'h0005;
    modeReg[4].countStart = 1'b1;
    modeReg[4].oneShotStart = 1'b1;
    @(negedge sys_clk);
    modeReg[4].oneShotStart = 1'b0;
    waitOut(4, 1'b1, n);
    waitOut(4, 1'b0, n);
    waitOut(4, 1'b1, n);
    chk("low time", 16'h0028, 16'(n));
    waitOut(4, 1'b0, n);
    chk("high time", 16'h0010, 16'(n));
  endtask

  initial begin
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    testTimer();
    testEvent();
    testQuad();
    testOneShot();
    testPwm();
    testProg();
    results();
  end
endmodule // mtg_timer_group_tb

bind mtg_timer_group mtg_timer_group_checker mtg_timer_group_checker_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .chanModeReg(chanModeReg),
  .chanInPin(chanInPin), .chanOutPinIn(chanOutPinIn), .indexPhaseIn(indexPhaseIn),
  .chanOutPinOut(chanOutPinOut), .chanOutPinOe(chanOutPinOe),
  .chanIrqReq(chanIrqReq), .chanCount(chanCount));
